//--- rtl/catm_map.vh
`ifndef CATM_MAP_VH
`define CATM_MAP_VH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define CATM_ADDR_TAG1        8'hBC
`define CATM_ADDR_TAG2        8'hBD
`define CATM_ADDR_TAG3        8'hBE
`define CATM_ADDR_TAG4        8'hBF
`define CATM_ADDR_MSK1        8'hC4
`define CATM_ADDR_MSK2        8'hC5
`define CATM_ADDR_MSK3        8'hC6
`define CATM_ADDR_MSK4        8'hC7

// ----------------------------------------------------------------------------
// Sizes and field positions
// ----------------------------------------------------------------------------
`define CATM_NUM_OBJ          4
`define CATM_OBJ_W            2
`define CATM_ID_W             29
`define CATM_STD_ID_W         11
`define CATM_BIT_RTR          2
`define CATM_BIT_RB1          1
`define CATM_BIT_RB0          0
`define CATM_BIT_IDE          0
`define CATM_TAG4_LSB         24
`define CATM_STD_LOW_MASK     8'hE0
`define CATM_STD_FLAG_MASK    8'h05
`define CATM_EXT_FLAG_MASK    8'hFF
`define CATM_MSK4_STD_MASK    8'h05
`define CATM_MSK4_EXT_MASK    8'hFD
`define CATM_ZERO_BYTE        8'h00

`endif

//--- rtl/catm_bank.v
`timescale 1ns/1ps
`include "catm_map.vh"

// ----------------------------------------------------------------------------
// One object's tag and mask storage, no reset value.
// ----------------------------------------------------------------------------
module catm_bank (
    // Clock
    input  wire        clk,
    // Write port
    input  wire        wr_en,
    input  wire [2:0]  wr_sel,
    input  wire [7:0]  wr_data,
    // Stored bytes
    output wire [63:0] regs
);
    wire [7:0] sel_hot = 8'h01 << wr_sel;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_byte
            reg [7:0] byte_q;

            always @(posedge clk) begin
                if (wr_en && sel_hot[g]) begin
                    byte_q <= wr_data;
                end
            end
            assign regs[g*8 +: 8] = byte_q;
        end
    endgenerate
endmodule

//--- rtl/catm_match.v
`timescale 1ns/1ps
`include "catm_map.vh"

// ----------------------------------------------------------------------------
// Masked acceptance compare for one object.
// ----------------------------------------------------------------------------
module catm_match (
    // Frame fields
    input  wire [28:0] rx_id,
    input  wire        rx_rtr,
    input  wire        rx_ide,
    input  wire        rx_rb1,
    input  wire        rx_rb0,
    // Object setup
    input  wire        ext_sel,
    input  wire [63:0] regs,
    // Result
    output wire        hit
);
    wire [7:0]  t1 = regs[7:0];
    wire [7:0]  t2 = regs[15:8];
    wire [7:0]  t3 = regs[23:16];
    wire [7:0]  t4 = regs[31:24];
    wire [7:0]  m1 = regs[39:32];
    wire [7:0]  m2 = regs[47:40];
    wire [7:0]  m3 = regs[55:48];
    wire [7:0]  m4 = regs[63:56];
    wire [28:0] tag_ext = {t1, t2, t3, t4[7:3]};
    wire [28:0] msk_ext = {m1, m2, m3, m4[7:3]};
    wire [10:0] tag_std = {t1, t2[7:5]};
    wire [10:0] msk_std = {m1, m2[7:5]};
    wire        id_ok;
    wire        rtr_ok;
    wire        ide_ok;
    wire        rb_ok;

    // Mask bit 0 forces the compare true; mask bit 1 enables it.
    assign id_ok  = ext_sel ? (((rx_id ^ tag_ext) & msk_ext) == 29'h0000000)
                            : (((rx_id[10:0] ^ tag_std) & msk_std) == 11'h000);
    assign rtr_ok = ~((rx_rtr ^ t4[`CATM_BIT_RTR]) & m4[`CATM_BIT_RTR]);
    assign ide_ok = ~((rx_ide ^ ext_sel) & m4[`CATM_BIT_IDE]);
    // Reserved-bit tags are stored in every layout but compared only where the layout holds them.
    assign rb_ok  = (rx_rb0 == t4[`CATM_BIT_RB0]) &&
                    (~ext_sel || rx_rb1 == t4[`CATM_BIT_RB1]);
    assign hit    = id_ok & rtr_ok & ide_ok & rb_ok;
endmodule

//--- rtl/catm_tag_mask.v
// Operation
// - A mask bit of 0 forces its identifier bit compare true, a 1 enables it.
// - Masks only filter received frames and never touch transmitted ones.
// - Mask register four bit 2 forces or enables the remote-request compare.
// - Mask register four bit 0 forces or enables the extension-flag compare.
// - Standard tag register four holds remote-request at bit 2, reserved-0 at bit 0.
// - Extended tag register four holds id 4..0 in bits 7..3 plus three flag tags.
// - The reserved-1 tag lives at bit 1 only in the extended layout and is compared.
// - Extended tag registers one to three hold id 28..21, 20..13 and 12..5.
// - Extended mask registers one and two hold mask 28..21 and 20..13.
// - Standard mask one holds mask 10..3, mask two holds mask 2..0 in bits 7..5.
// - Standard mask register three has only reserved bits.
// - Tag and mask registers get no value from reset.
// - The extension select picks the 11-bit layout at 0 and 29-bit at 1.
// - Standard tag one holds id 10..3, tag two holds id 2..0 in bits 7..5.
`timescale 1ns/1ps
`include "catm_map.vh"

module catm_tag_mask (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // Register port
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_wdata,
    output wire [7:0]  reg_rdata,
    output wire        reg_hit,
    // Object selection and configuration
    input  wire [1:0]  page_obj,
    input  wire [3:0]  obj_ext_sel,
    input  wire [3:0]  obj_rx_enable,
    // Received frame fields
    input  wire        rx_valid,
    input  wire [28:0] rx_id,
    input  wire        rx_rtr,
    input  wire        rx_ide,
    input  wire        rx_rb1,
    input  wire        rx_rb0,
    // Acceptance result
    output wire [3:0]  rx_accept,
    output wire        rx_accept_valid,
    // Transmit view of the paged object
    output wire [28:0] tx_id,
    output wire        tx_ide,
    output wire        tx_rtr,
    output wire        tx_rb1,
    output wire        tx_rb0
);
    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    reg  [2:0]   sel;
    reg          sel_ok;
    wire [255:0] bank_regs;
    wire [63:0]  page_regs;
    wire         page_ext;
    reg  [7:0]   raw;
    reg  [7:0]   rd_q;
    reg  [3:0]   accept_q;
    reg          accept_v_q;
    wire [3:0]   hits;
    wire [3:0]   page_hot;

    always @* begin
        sel_ok = 1'b1;
        sel    = 3'd0;
        case (reg_addr)
            `CATM_ADDR_TAG1: sel = 3'd0;
            `CATM_ADDR_TAG2: sel = 3'd1;
            `CATM_ADDR_TAG3: sel = 3'd2;
            `CATM_ADDR_TAG4: sel = 3'd3;
            `CATM_ADDR_MSK1: sel = 3'd4;
            `CATM_ADDR_MSK2: sel = 3'd5;
            `CATM_ADDR_MSK3: sel = 3'd6;
            `CATM_ADDR_MSK4: sel = 3'd7;
            default:         sel_ok = 1'b0;
        endcase
    end

    assign reg_hit  = sel_ok;
    assign page_hot = 4'h1 << page_obj;

    // ------------------------------------------------------------------------
    // Per-object storage and compare
    // ------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `CATM_NUM_OBJ; g = g + 1) begin : g_obj
            // Registers are plain storage without reset.
            catm_bank u_bank (
                .clk     (clk),
                .wr_en   (reg_wr && sel_ok && page_hot[g]),
                .wr_sel  (sel),
                .wr_data (reg_wdata),
                .regs    (bank_regs[g*64 +: 64])
            );
            catm_match u_match (
                .rx_id   (rx_id),
                .rx_rtr  (rx_rtr),
                .rx_ide  (rx_ide),
                .rx_rb1  (rx_rb1),
                .rx_rb0  (rx_rb0),
                .ext_sel (obj_ext_sel[g]),
                .regs    (bank_regs[g*64 +: 64]),
                .hit     (hits[g])
            );
        end
    endgenerate

    assign page_regs = bank_regs[page_obj*64 +: 64];
    assign page_ext  = obj_ext_sel[page_obj];

    // ------------------------------------------------------------------------
    // Read path, layout aware
    // ------------------------------------------------------------------------
    always @* begin
        raw = page_regs[sel*8 +: 8];
        case (sel)
            3'd1: raw = page_ext ? raw : (raw & `CATM_STD_LOW_MASK);
            3'd2: raw = page_ext ? raw : `CATM_ZERO_BYTE;
            3'd3: raw = page_ext ? (raw & `CATM_EXT_FLAG_MASK)
                                 : (raw & `CATM_STD_FLAG_MASK);
            3'd5: raw = page_ext ? raw : (raw & `CATM_STD_LOW_MASK);
            3'd6: raw = page_ext ? raw : `CATM_ZERO_BYTE;
            3'd7: raw = page_ext ? (raw & `CATM_MSK4_EXT_MASK)
                                 : (raw & `CATM_MSK4_STD_MASK);
            default: raw = raw;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            rd_q <= `CATM_ZERO_BYTE;
        end else if (reg_rd && sel_ok) begin
            rd_q <= raw;
        end
    end

    assign reg_rdata = rd_q;

    // ------------------------------------------------------------------------
    // Acceptance, reception objects only
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            accept_q   <= 4'h0;
            accept_v_q <= 1'b0;
        end else begin
            accept_v_q <= rx_valid;
            accept_q   <= rx_valid ? (hits & obj_rx_enable) : 4'h0;
        end
    end

    assign rx_accept       = accept_q;
    assign rx_accept_valid = accept_v_q;

    // ------------------------------------------------------------------------
    // Transmit fields ignore the mask entirely
    // ------------------------------------------------------------------------
    assign tx_ide = page_ext;
    assign tx_id  = page_ext ? {page_regs[7:0], page_regs[15:8], page_regs[23:16],
                                page_regs[31:27]}
                             : {18'h00000, page_regs[7:0], page_regs[15:13]};
    assign tx_rtr = page_regs[`CATM_TAG4_LSB + `CATM_BIT_RTR];
    assign tx_rb1 = page_ext & page_regs[`CATM_TAG4_LSB + `CATM_BIT_RB1];
    assign tx_rb0 = page_regs[`CATM_TAG4_LSB + `CATM_BIT_RB0];
endmodule

//--- verif/catm_tag_mask_sva.sv
`timescale 1ns/1ps

module catm_tag_mask_sva (
    // Clock and reset
    input wire       clk,
    input wire       rst,
    // Register port
    input wire [7:0] reg_addr,
    input wire       reg_rd,
    input wire       reg_hit,
    input wire [7:0] reg_rdata,
    // Objects and frames
    input wire [1:0] page_obj,
    input wire [3:0] obj_ext_sel,
    input wire [3:0] obj_rx_enable,
    input wire       rx_valid,
    input wire [3:0] rx_accept,
    input wire       rx_accept_valid,
    input wire       tx_ide
);
    // ------------------------------------------------------------------
    // Register read layouts and acceptance timing.
    // ------------------------------------------------------------------
    wire rd_w  = reg_rd && reg_hit;
    wire std_w = !obj_ext_sel[page_obj];
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_acc_vld; rx_accept_valid == $past(rx_valid); endproperty
    a_acc_vld: assert property (p_acc_vld) else $error("accept valid wrong");
    property p_acc_idle; !rx_accept_valid |-> rx_accept == 4'h0; endproperty
    a_acc_idle: assert property (p_acc_idle) else $error("accept without valid");
    property p_rx_only; rx_valid |=> (rx_accept & ~$past(obj_rx_enable)) == 4'h0; endproperty
    a_rx_only: assert property (p_rx_only) else $error("hit on non rx object");
    property p_tag2; rd_w && std_w && reg_addr == 8'hBD |=> reg_rdata[4:0] == 5'h00; endproperty
    a_tag2: assert property (p_tag2) else $error("std tag2 low bits");
    property p_tag4; rd_w && std_w && reg_addr == 8'hBF |=> (reg_rdata & 8'hFA) == 8'h00; endproperty
    a_tag4: assert property (p_tag4) else $error("std tag4 layout");
    property p_msk2; rd_w && std_w && reg_addr == 8'hC5 |=> reg_rdata[4:0] == 5'h00; endproperty
    a_msk2: assert property (p_msk2) else $error("std mask2 low bits");
    property p_msk3; rd_w && std_w && reg_addr == 8'hC6 |=> reg_rdata == 8'h00; endproperty
    a_msk3: assert property (p_msk3) else $error("std mask3 not empty");
    property p_msk4; rd_w && std_w && reg_addr == 8'hC7 |=> (reg_rdata & 8'hFA) == 8'h00; endproperty
    a_msk4: assert property (p_msk4) else $error("std mask4 layout");
    property p_xmsk4; rd_w && !std_w && reg_addr == 8'hC7 |=> !reg_rdata[1]; endproperty
    a_xmsk4: assert property (p_xmsk4) else $error("ext mask4 bit1 set");
    property p_ide; tx_ide == obj_ext_sel[page_obj]; endproperty
    a_ide: assert property (p_ide) else $error("layout select wrong");
endmodule

bind catm_tag_mask catm_tag_mask_sva u_sva (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_hit(reg_hit),
    .reg_rdata(reg_rdata), .page_obj(page_obj), .obj_ext_sel(obj_ext_sel),
    .obj_rx_enable(obj_rx_enable), .rx_valid(rx_valid), .rx_accept(rx_accept),
    .rx_accept_valid(rx_accept_valid), .tx_ide(tx_ide));

//--- verif/catm_tag_mask_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end

module catm_tag_mask_test;
    logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rx_valid = 0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
    logic [1:0]  page_obj = 2'h0;
    logic [3:0]  obj_ext_sel = 4'h5, obj_rx_enable = 4'h7;
    logic [28:0] rx_id = 29'h0;
    logic        rx_rtr = 0, rx_ide = 0, rx_rb1 = 0, rx_rb0 = 0;
    wire  [7:0]  reg_rdata;
    wire  [3:0]  rx_accept;
    wire  [28:0] tx_id;
    wire         reg_hit, rx_accept_valid, tx_ide, tx_rtr, tx_rb1, tx_rb0;
    integer      err_count = 0, tests_run = 0, cyc = 0, k;
    localparam logic [28:0] ID_A = 29'h1B5AC3E9;
    localparam logic [31:0] T0   = {ID_A, 3'h5};
    localparam logic [31:0] T1   = {11'h5A3, 18'h0, 3'h5};
    // Frame fields, extension flag and expected hits per object.
    logic [36:0] vec [0:7] = '{{ID_A, 3'h5, 1'h1, 4'h5}, {ID_A ^ 29'h1, 3'h5, 1'h1, 4'h4},
        {ID_A, 3'h1, 1'h1, 4'h4}, {ID_A, 3'h5, 1'h0, 4'h4}, {29'h5AC, 3'h1, 1'h0, 4'h6},
        {29'h5BC, 3'h1, 1'h0, 4'h4}, {29'h5AC, 3'h0, 1'h0, 4'h0}, {ID_A, 3'h7, 1'h1, 4'h0}};

    catm_tag_mask i_dut (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .page_obj(page_obj), .obj_ext_sel(obj_ext_sel), .obj_rx_enable(obj_rx_enable),
        .rx_valid(rx_valid), .rx_id(rx_id), .rx_rtr(rx_rtr), .rx_ide(rx_ide),
        .rx_rb1(rx_rb1), .rx_rb0(rx_rb0), .rx_accept(rx_accept),
        .rx_accept_valid(rx_accept_valid), .tx_id(tx_id), .tx_ide(tx_ide),
        .tx_rtr(tx_rtr), .tx_rb1(tx_rb1), .tx_rb0(tx_rb0));

    initial begin
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            err_count++;
            stop_test;
        end
    end

    // ------------------------------------------------------------------
    // Register port and frame tasks.
    // ------------------------------------------------------------------
    task automatic wr(input [7:0] a, input [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge clk);
        reg_wr = 0;
    endtask

    task automatic rd(input [7:0] a, input [7:0] e);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1;
        @(negedge clk);
        reg_rd = 0;
        `CHK(reg_rdata, e)
    endtask

    task automatic load(input [1:0] o, input [31:0] t, input [31:0] m);
        integer i;
        page_obj = o;
        for (i = 0; i < 8; i++) begin
            wr(8'(8'hBC + i % 4 + 8 * (i / 4)), i < 4 ? t[31 - 8 * i -: 8] : m[63 - 8 * i -: 8]);
        end
        for (i = 0; i < 8; i++) begin
            rd(8'(8'hBC + i % 4 + 8 * (i / 4)), i < 4 ? t[31 - 8 * i -: 8] : m[63 - 8 * i -: 8]);
        end
    endtask

    task automatic frm(input [36:0] v);
        @(negedge clk);
        {rx_id, rx_rtr, rx_rb1, rx_rb0, rx_ide} = v[36:4];
        rx_valid = 1;
        @(negedge clk);
        rx_valid = 0;
        `CHK({rx_accept_valid, rx_accept}, {1'h1, v[3:0]})
    endtask

    task stop_test;
        if (err_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(negedge clk);
        rst = 0;
        load(2'h1, T1, {11'h7F0, 18'h0, 3'h1});
        load(2'h2, {29'h0A5A5A5A, 3'h1}, 32'h0);
        load(2'h3, T1, 32'h0);
        `CHK({tx_ide, tx_id, tx_rtr, tx_rb1, tx_rb0}, {1'h0, 29'h5A3, 3'h5})
        load(2'h0, T0, 32'hFFFFFFFD);
        `CHK(reg_hit, 1'h1)
        rd(8'hC3, 8'hFD);
        `CHK(reg_hit, 1'h0)
        `CHK({tx_ide, tx_id, tx_rtr, tx_rb1, tx_rb0}, {1'h1, T0})
        for (k = 0; k < 8; k++) begin
            frm(vec[k]);
        end
        for (k = 0; k < 4; k++) begin
            wr(8'(8'hC4 + k), 8'h00);
        end
        `CHK({tx_ide, tx_id, tx_rtr, tx_rb1, tx_rb0}, {1'h1, T0})
        frm(37'({ID_A ^ 29'h1, 3'h5, 1'h1, 4'h5}));
        stop_test;
    end
endmodule
